// *** rtl/iops_map.svh ***
// iops_map.svh: timing constants and the ns-to-cycle conversion for the power-up sequencer
// assumes the includer works at the 200 MHz core clock
`ifndef IOPS_MAP_SVH
`define IOPS_MAP_SVH

`define IOPS_CLK_PERIOD_PS 5000
// variant A figures
`define IOPS_A_POR_SHORT_NS 12000000
`define IOPS_A_POR_LONG_NS 100000000
`define IOPS_A_ADD_INST_NS 33000
`define IOPS_A_ADD_DLY_NS 50000000
`define IOPS_A_CD_NS 600
`define IOPS_A_UM_NS 25000
`define IOPS_A_ST0_NS 800
`define IOPS_A_ST1_NS 100000
// variant B figures
`define IOPS_B_POR_SHORT_NS 2000000
`define IOPS_B_POR_LONG_NS 100000000
`define IOPS_B_ADD_INST_NS 4000000
`define IOPS_B_ADD_DLY_NS 50000000
`define IOPS_B_CD_NS 500
`define IOPS_B_UM_NS 6000
`define IOPS_B_ST0_NS 800
`define IOPS_B_ST1_NS 40000
// variant C figures
`define IOPS_C_POR_NS 5000
`define IOPS_C_ADD_INST_NS 0
`define IOPS_C_ADD_DLY_NS 50000000
`define IOPS_C_CD_NS 500
`define IOPS_C_UM_NS 2500
`define IOPS_C_ST0_NS 200
`define IOPS_C_ST1_NS 1000
// least time in ns to cycles, rounded up, never below one
// worked in 64 bits: the 100 ms figures in ps overflow a 32-bit int
`define IOPS_CYC(ns) int'((((64'(ns) * 64'd1000 + 64'(`IOPS_CLK_PERIOD_PS) - 64'd1) / \
  64'(`IOPS_CLK_PERIOD_PS)) < 64'd1) ? 64'd1 : ((64'(ns) * 64'd1000 + \
  64'(`IOPS_CLK_PERIOD_PS) - 64'd1) / 64'(`IOPS_CLK_PERIOD_PS)))

`endif

// *** rtl/iops_pkg.sv ***
// iops_pkg: types for the instant-on power-up sequencer
// assumes iops_map.svh carries the numbers
package iops_pkg;
  typedef enum logic [1:0] {
    IOPS_VAR_A = 2'h0,
    IOPS_VAR_B = 2'h1,
    IOPS_VAR_C = 2'h2
  } iops_variant_t;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    IOPS_ST_POR = 6'h01,
    IOPS_ST_HOLD = 6'h02,
    IOPS_ST_ADD = 6'h04,
    IOPS_ST_CD = 6'h08,
    IOPS_ST_UM = 6'h10,
    IOPS_ST_RUN = 6'h20
  } iops_state_t;

  // pin group toward the board controller
  typedef struct packed {
    logic status_n;
    logic config_done;
    logic chain_enable_out_n;
    logic init_complete;
  } iops_pins_t;
endpackage

// *** rtl/iops_delay_cnt.sv ***
// iops_delay_cnt: loadable down counter timing one sequencer phase
// assumes the caller loads a nonzero count and holds ce for running
`timescale 1ns/1ps
module iops_delay_cnt #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic expired
);
  logic [W-1:0] cnt_q;

  // load wins over counting so a phase change restarts timing cleanly
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_q <= count;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

  assign expired = (cnt_q == W'(1)) && !load;
endmodule // iops_delay_cnt

// *** rtl/iops_pullup_ctrl.sv ***
// iops_pullup_ctrl: weak pull-up enables for user and configuration pins
// assumes the pad ring applies the enables it gets
`timescale 1ns/1ps
module iops_pullup_ctrl #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic init_phase,
  input wire logic weak_pullup_off,
  output logic user_io_pullup_en,
  output logic cfg_clk_pullup_en,
  output logic [DATA_W-1:0] cfg_data_pullup_en
);
  // user pull-ups live only while not yet in user mode
  always_ff @(posedge clk) begin
    if (rst) begin
      user_io_pullup_en <= 1'b1;
    end else if (ce) begin
      user_io_pullup_en <= init_phase && !weak_pullup_off;
    end
  end

  // config inputs always held high so floating pins stay defined
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_clk_pullup_en <= 1'b1;
    end else if (ce) begin
      cfg_clk_pullup_en <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_data
      always_ff @(posedge clk) begin
        if (rst) begin
          cfg_data_pullup_en[gi] <= 1'b1;
        end else if (ce) begin
          cfg_data_pullup_en[gi] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule // iops_pullup_ctrl

// *** rtl/iops_sequencer.sv ***
// iops_sequencer: instant-on power-up and restart sequencer
// assumes rst is the internal power-on reset and pins are synchronous to clk
`timescale 1ns/1ps
`include "iops_map.svh"
module iops_sequencer
  import iops_pkg::*;
#(
  parameter iops_variant_t VARIANT = IOPS_VAR_B,
  parameter bit DELAYED_MODE = 1'b0,
  parameter bit INIT_DONE_EN = 1'b1,
  parameter int DATA_W = 8,
  parameter int POR_SHORT_CYC = (VARIANT == IOPS_VAR_A) ? `IOPS_CYC(`IOPS_A_POR_SHORT_NS) :
    (VARIANT == IOPS_VAR_B) ? `IOPS_CYC(`IOPS_B_POR_SHORT_NS) : `IOPS_CYC(`IOPS_C_POR_NS),
  parameter int POR_LONG_CYC = (VARIANT == IOPS_VAR_A) ? `IOPS_CYC(`IOPS_A_POR_LONG_NS) :
    (VARIANT == IOPS_VAR_B) ? `IOPS_CYC(`IOPS_B_POR_LONG_NS) : `IOPS_CYC(`IOPS_C_POR_NS),
  parameter int ADD_CYC = DELAYED_MODE ?
    ((VARIANT == IOPS_VAR_A) ? `IOPS_CYC(`IOPS_A_ADD_DLY_NS) :
     (VARIANT == IOPS_VAR_B) ? `IOPS_CYC(`IOPS_B_ADD_DLY_NS) : `IOPS_CYC(`IOPS_C_ADD_DLY_NS)) :
    ((VARIANT == IOPS_VAR_A) ? `IOPS_CYC(`IOPS_A_ADD_INST_NS) :
     (VARIANT == IOPS_VAR_B) ? `IOPS_CYC(`IOPS_B_ADD_INST_NS) : `IOPS_CYC(`IOPS_C_ADD_INST_NS)),
  parameter int ST1_CYC = (VARIANT == IOPS_VAR_A) ? `IOPS_CYC(`IOPS_A_ST1_NS) :
    (VARIANT == IOPS_VAR_B) ? `IOPS_CYC(`IOPS_B_ST1_NS) : `IOPS_CYC(`IOPS_C_ST1_NS)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic config_restart_n,
  input wire logic chip_select_in_n,
  input wire logic por_delay_select,
  input wire logic weak_pullup_off,
  output iops_pins_t pins,
  output logic status_n_oe_n,
  output logic config_done_oe_n,
  output logic init_complete_oe_n,
  output logic ctl_pins_pullup_en,
  output logic user_io_pullup_en,
  output logic cfg_clk_pullup_en,
  output logic [DATA_W-1:0] cfg_data_pullup_en
);
  localparam int CW = 32;
  localparam int CD_CYC = (VARIANT == IOPS_VAR_A) ? `IOPS_CYC(`IOPS_A_CD_NS) :
    (VARIANT == IOPS_VAR_B) ? `IOPS_CYC(`IOPS_B_CD_NS) : `IOPS_CYC(`IOPS_C_CD_NS);
  localparam int UM_CYC = (VARIANT == IOPS_VAR_A) ? `IOPS_CYC(`IOPS_A_UM_NS) :
    (VARIANT == IOPS_VAR_B) ? `IOPS_CYC(`IOPS_B_UM_NS) : `IOPS_CYC(`IOPS_C_UM_NS);

  iops_state_t state_q, state_d;
  logic restart_q;
  logic load_q;
  logic [CW-1:0] load_cnt;
  logic expired;
  logic restart_fall;
  logic init_phase;

  // previous restart level, gives the falling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      restart_q <= 1'b1;
    end else if (ce) begin
      restart_q <= config_restart_n;
    end
  end
  assign restart_fall = restart_q && !config_restart_n;

  // variant C has a single fixed delay, so the select pin is ignored there
  always_comb begin
    load_cnt = CW'(POR_SHORT_CYC);
    case (state_q)
      IOPS_ST_POR: begin
        if (VARIANT != IOPS_VAR_C && por_delay_select) begin
          load_cnt = CW'(POR_LONG_CYC);
        end
      end
      IOPS_ST_HOLD: load_cnt = CW'(ST1_CYC);
      IOPS_ST_ADD: load_cnt = CW'(ADD_CYC);
      IOPS_ST_CD: load_cnt = CW'(CD_CYC);
      IOPS_ST_UM: load_cnt = CW'(UM_CYC);
      default: load_cnt = CW'(1);
    endcase
  end

  iops_delay_cnt #(
    .W(CW)
  ) u_cnt (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(load_q),
    .count(load_cnt),
    .expired(expired)
  );

  // next state; a restart edge anywhere starts over
  always_comb begin
    state_d = state_q;
    case (state_q)
      IOPS_ST_POR: begin
        if (expired) begin
          state_d = config_restart_n ? IOPS_ST_ADD : IOPS_ST_HOLD;
        end
      end
      IOPS_ST_HOLD: begin
        // restart release time models the status_n release delay
        if (expired && config_restart_n) begin
          state_d = IOPS_ST_ADD;
        end
      end
      IOPS_ST_ADD: if (expired) state_d = IOPS_ST_CD;
      IOPS_ST_CD: if (expired) state_d = IOPS_ST_UM;
      IOPS_ST_UM: if (expired) state_d = IOPS_ST_RUN;
      IOPS_ST_RUN: state_d = IOPS_ST_RUN;
      default: state_d = IOPS_ST_POR;
    endcase
    if (restart_fall) begin
      state_d = IOPS_ST_HOLD;
    end
  end

  // sequence state and counter reload request
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= IOPS_ST_POR;
      load_q <= 1'b1;
    end else if (ce) begin
      state_q <= state_d;
      load_q <= (state_d != state_q) || (state_q == IOPS_ST_HOLD && !config_restart_n);
    end
  end

  // status_n low while restart is asserted or holding; low within one edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pins.status_n <= 1'b0;
      status_n_oe_n <= 1'b0;
    end else if (ce) begin
      pins.status_n <= !(state_d == IOPS_ST_POR || state_d == IOPS_ST_HOLD);
      status_n_oe_n <= (state_d == IOPS_ST_POR || state_d == IOPS_ST_HOLD);
    end
  end

  // done is open drain: pulled low until the added wait ends, then released
  always_ff @(posedge clk) begin
    if (rst) begin
      pins.config_done <= 1'b0;
      config_done_oe_n <= 1'b0;
      pins.chain_enable_out_n <= 1'b1;
    end else if (ce) begin
      pins.config_done <= (state_d == IOPS_ST_UM || state_d == IOPS_ST_RUN ||
                           state_d == IOPS_ST_CD && state_q == IOPS_ST_CD);
      config_done_oe_n <= (state_d == IOPS_ST_CD || state_d == IOPS_ST_UM ||
                           state_d == IOPS_ST_RUN);
      // chain enable follows done release, only when this device is selected
      pins.chain_enable_out_n <= !((state_d == IOPS_ST_CD || state_d == IOPS_ST_UM ||
                                    state_d == IOPS_ST_RUN) && !chip_select_in_n);
    end
  end

  // init_complete low from sequence start; rises after done has been high
  always_ff @(posedge clk) begin
    if (rst) begin
      pins.init_complete <= 1'b0;
      init_complete_oe_n <= 1'b0;
    end else if (ce) begin
      // when unused the pin is left undriven once out of reset (reset drives it low), a fixed build choice
      pins.init_complete <= INIT_DONE_EN && state_d == IOPS_ST_RUN &&
                            pins.config_done;
      init_complete_oe_n <= !INIT_DONE_EN || state_d == IOPS_ST_RUN;
    end
  end

  // control pins keep their weak pull-ups so they idle high
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_pins_pullup_en <= 1'b1;
    end else if (ce) begin
      ctl_pins_pullup_en <= 1'b1;
    end
  end

  assign init_phase = (state_q != IOPS_ST_RUN);

  iops_pullup_ctrl #(
    .DATA_W(DATA_W)
  ) u_pull (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .init_phase(init_phase),
    .weak_pullup_off(weak_pullup_off),
    .user_io_pullup_en(user_io_pullup_en),
    .cfg_clk_pullup_en(cfg_clk_pullup_en),
    .cfg_data_pullup_en(cfg_data_pullup_en)
  );
endmodule // iops_sequencer

// *** verification/iops_seq_assertions.sv ***
// iops_seq_assertions: port-level checks on the power-up sequencer
// assumes a bind to iops_sequencer; all checks sit in the clk domain
`timescale 1ns/1ps
module iops_seq_assertions
  import iops_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic config_restart_n,
  input wire logic weak_pullup_off,
  input wire iops_pins_t pins,
  input wire logic config_done_oe_n,
  input wire logic ctl_pins_pullup_en,
  input wire logic user_io_pullup_en,
  input wire logic cfg_clk_pullup_en,
  input wire logic [DATA_W-1:0] cfg_data_pullup_en
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // restart edge as the sequencer takes it
  sequence s_restart;
    ce && $fell(config_restart_n);
  endsequence
  sequence s_status_low;
    !pins.status_n;
  endsequence
  AST_RESTART_STATUS: assert property (s_restart |=> s_status_low)
    else $error("status not driven low after restart");
  AST_HELD_LOW: assert property (ce && !config_restart_n && !$past(config_restart_n) |-> s_status_low)
    else $error("status released while restart held low");
  AST_NO_BLIP: assert property (s_status_low ##1 s_status_low |-> !pins.init_complete)
    else $error("init complete high during restart");
  AST_INIT_AFTER_DONE: assert property ($rose(pins.init_complete) |-> $past(pins.config_done))
    else $error("init complete rose without done");
  AST_DONE_RELEASED: assert property (pins.config_done |-> config_done_oe_n && pins.status_n)
    else $error("done high while held or status low");
  AST_CHAIN_DONE: assert property ($fell(pins.chain_enable_out_n) |-> ##[0:2] pins.config_done)
    else $error("chain enable without done release");
  // settled init phase: status released, done not yet up
  AST_USER_PULLUP: assert property (!weak_pullup_off && !$past(weak_pullup_off) && pins.status_n
    && !pins.config_done |-> user_io_pullup_en)
    else $error("user pull-up off during init");
  AST_FIXED_PULLUPS: assert property (ctl_pins_pullup_en && cfg_clk_pullup_en
    && (&cfg_data_pullup_en))
    else $error("fixed pull-up dropped");
endmodule // iops_seq_assertions

// *** verification/iops_board_ctl.sv ***
// iops_board_ctl: board controller model for restart and chip select
// assumes the bench calls drive from a single process
`timescale 1ns/1ps
module iops_board_ctl (
  input wire logic clk,
  output logic config_restart_n,
  output logic chip_select_in_n
);
  // idle: restart released, chip selected; status and done never pulled low
  initial begin
    config_restart_n = 1'b1;
    chip_select_in_n = 1'b0;
  end
  // pins change just after an edge, never on it
  task automatic drive(input logic r, input logic c);
    @(posedge clk);
    #1;
    config_restart_n = r;
    chip_select_in_n = c;
  endtask
endmodule // iops_board_ctl

// *** verification/iops_sequencer_tb.sv ***
// iops_sequencer_tb: boots and restarts the sequencer against timing windows
// assumes variant B with shortened power-on, added-wait and status counts
`timescale 1ns/1ps
module iops_sequencer_tb;
  import iops_pkg::*;
  localparam int POR_S = 20, POR_L = 40, ADD = 15, ST1 = 10;
  localparam int CDUM = 1300; // done plus user-mode delay, 0.5 us + 6 us at 5 ns
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, sel = 1'b0, wpo = 1'b0;
  logic restart_n, cs_n, st_oe, cd_oe, ic_oe, ctl_pu, user_pu, clk_pu;
  logic [7:0] data_pu;
  iops_pins_t pins;
  int fail_count = 0, total_checks = 0, cyc = 0, n;
  always #2.5 clk = ~clk;
  // hang guard, well above five full sequences
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      test_done();
    end
  end
  iops_board_ctl u_iops_board_ctl (.clk(clk), .config_restart_n(restart_n),
    .chip_select_in_n(cs_n));
  iops_sequencer #(.VARIANT(IOPS_VAR_B), .POR_SHORT_CYC(POR_S), .POR_LONG_CYC(POR_L),
    .ADD_CYC(ADD), .ST1_CYC(ST1)) u_iops_sequencer (.clk(clk), .rst(rst), .ce(ce),
    .config_restart_n(restart_n), .chip_select_in_n(cs_n), .por_delay_select(sel),
    .weak_pullup_off(wpo), .pins(pins), .status_n_oe_n(st_oe), .config_done_oe_n(cd_oe),
    .init_complete_oe_n(ic_oe), .ctl_pins_pullup_en(ctl_pu), .user_io_pullup_en(user_pu),
    .cfg_clk_pullup_en(clk_pu), .cfg_data_pullup_en(data_pu));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_win(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask
  // cycles until pin bit b reaches v; bits 3 down to 0 are status, done, chain, init
  task automatic wait_pin(input int b, input logic v, output int k);
    k = 0;
    while (pins[b] !== v && k < 5000) begin
      @(posedge clk);
      #1 k++;
    end
  endtask
  // from status release to user mode
  task automatic tail();
    chk(user_pu, !wpo);
    wait_pin(2, 1'b1, n);
    chk_win(n, ADD, ADD + 4);
    chk(pins.chain_enable_out_n, cs_n);
    chk(pins.init_complete, 1'b0);
    // counted from done rising, one cycle after its release
    wait_pin(0, 1'b1, n);
    chk_win(n, CDUM - 1, CDUM + 5);
    repeat (2) @(posedge clk);
    #1 chk(user_pu, 1'b0);
  endtask
  task automatic boot(input logic s, input logic w, input logic c);
    rst = 1'b1;
    sel = s;
    wpo = w;
    u_iops_board_ctl.drive(1'b1, c);
    repeat (4) @(posedge clk);
    #1 chk(pins, 32'h2);
    chk({ctl_pu, clk_pu, user_pu, data_pu}, 32'h7FF);
    rst = 1'b0;
    wait_pin(3, 1'b1, n);
    chk_win(n, s ? POR_L : POR_S, (s ? POR_L : POR_S) + 4);
    tail();
  endtask
  // restart pulse of len + 1 cycles, len at least 2
  task automatic restart(input int len);
    u_iops_board_ctl.drive(1'b0, cs_n);
    repeat (2) @(posedge clk);
    #1 chk({pins.status_n, pins.init_complete}, 32'h0);
    repeat (len - 2) @(posedge clk);
    #1 chk(pins.status_n, 1'b0);
    u_iops_board_ctl.drive(1'b1, cs_n);
    wait_pin(3, 1'b1, n);
    chk_win(n, ST1, ST1 + 4);
    tail();
  endtask
  initial begin
    n = $urandom(82);
    boot(1'b0, 1'b0, 1'b0);
    restart(2 + $urandom_range(4));
    restart(POR_L + 5 + $urandom_range(20));
    boot(1'b1, 1'b1, 1'b1);
    boot(1'b0, $urandom_range(1), 1'b0);
    // frozen clock enable: a restart pulse must leave the run state untouched
    ce = 1'b0;
    u_iops_board_ctl.drive(1'b0, cs_n);
    repeat (3) @(posedge clk);
    #1 chk(pins, 32'hD);
    u_iops_board_ctl.drive(1'b1, cs_n);
    ce = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(pins, 32'hD);
    test_done();
  end
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule // iops_sequencer_tb

bind iops_sequencer iops_seq_assertions #(.DATA_W(DATA_W)) u_iops_seq_assertions (
  .clk(clk), .rst(rst), .ce(ce), .config_restart_n(config_restart_n),
  .weak_pullup_off(weak_pullup_off), .pins(pins), .config_done_oe_n(config_done_oe_n),
  .ctl_pins_pullup_en(ctl_pins_pullup_en), .user_io_pullup_en(user_io_pullup_en),
  .cfg_clk_pullup_en(cfg_clk_pullup_en), .cfg_data_pullup_en(cfg_data_pullup_en));
